// >>> src/mce_map.svh
// Register offsets, field positions, reset values and timing counts of the counter unit
`ifndef MCE_MAP_SVH
`define MCE_MAP_SVH

`define MCE_OFS_CTRL      8'h00
`define MCE_OFS_MODULO    8'h04
`define MCE_OFS_COUNT     8'h08
`define MCE_OFS_SCAN      8'h0c
`define MCE_OFS_IDXLATCH  8'h10
`define MCE_OFS_MEAS      8'h14
`define MCE_OFS_STATUS    8'h18
`define MCE_OFS_CMD       8'h1c

`define MCE_CTRL_W        21
`define MCE_CTRL_RST      21'h0
`define MCE_MODULO_RST    32'hffffffff

`define MCE_F_MODE_LO     0
`define MCE_F_MODE_HI     2
`define MCE_F_ENCRES_LO   3
`define MCE_F_ENCRES_HI   4
`define MCE_F_LIMIT_LO    5
`define MCE_F_LIMIT_HI    6
`define MCE_F_INDEX_LO    7
`define MCE_F_INDEX_HI    9
`define MCE_F_IDXFALL     10
`define MCE_F_CLRREAD     11
`define MCE_F_UPDOWN      12
`define MCE_F_PERN_LO     13
`define MCE_F_PERN_HI     14
`define MCE_F_RES_LO      15
`define MCE_F_RES_HI      16
`define MCE_F_WIDE        17
`define MCE_F_PWFALL      18
`define MCE_F_TMAFALL     19
`define MCE_F_TMIFALL     20

`define MCE_CMD_CLEAR     0

`define MCE_PER_N0        10'd1
`define MCE_PER_N1        10'd10
`define MCE_PER_N2        10'd100
`define MCE_PER_N3        10'd1000

`define MCE_CLK_NS        100
`define MCE_RES0_NS       20
`define MCE_RES1_NS       200
`define MCE_RES2_NS       2000
`define MCE_RES3_NS       20000
`define MCE_RES0_INC      (`MCE_CLK_NS / `MCE_RES0_NS)
`define MCE_RES1_DIV      (`MCE_RES1_NS / `MCE_CLK_NS)
`define MCE_RES2_DIV      (`MCE_RES2_NS / `MCE_CLK_NS)
`define MCE_RES3_DIV      (`MCE_RES3_NS / `MCE_CLK_NS)

`endif

// >>> src/mce_pkg.sv
// Types shared by the counter unit modules
`include "mce_map.svh"
package mce_pkg;

   typedef enum logic [2:0] {
      MODE_COUNT, MODE_ENCODER, MODE_PERIOD, MODE_WIDTH, MODE_TIMING
   } mce_mode_e;

   typedef enum logic [1:0] {RES_1X, RES_2X, RES_4X} mce_encres_e;

   typedef enum logic [1:0] {
      LIM_TOTALIZE, LIM_WRAPAROUND_LIMIT_MODE, LIM_RANGE, LIM_SINGLE_SHOT
   } mce_limit_e;

   typedef enum logic [2:0] {
      IDX_MARKER_IGNORE_MODE, IDX_CLEAR, IDX_GATE, IDX_LATCH, IDX_DECREMENT
   } mce_index_e;

   typedef struct packed {
      logic prev;
      logic level;
      logic rise;
      logic fall;
   } mce_edge_s;

   typedef struct packed {
      logic [`MCE_CTRL_W-1:0] ctrl;
      logic [31:0]            modulo;
      logic [31:0]            count;
      logic [31:0]            scanData;
      logic                   scanValid;
      logic [31:0]            idxLatch;
      logic [31:0]            measResult;
      logic [31:0]            timer;
      logic [9:0]             periods;
      logic [7:0]             divCnt;
      logic                   measRun;
      logic                   stopped;
      logic [31:0]            rdata;
   } mce_state_s;

endpackage

// >>> src/mce_edge.sv
// Input sampler giving level and one-cycle rise and fall pulses
module mce_edge (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Sampled input
   input  wire logic din,
   // Level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);
   import mce_pkg::*;

   mce_edge_s s;
   mce_edge_s next_s;

   always_comb begin
      next_s       = s;
      next_s.prev  = s.level;
      next_s.level = din;
      next_s.rise  = din & ~s.level;
      next_s.fall  = ~din & s.level;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.level;
   assign rise  = s.rise;
   assign fall  = s.fall;
endmodule

// >>> src/mce_counter.sv
// Multimode counter, quadrature decoder and time measurement unit with APB registers
//
// How it works
// - 1X encoder counts phase A rising only
// - 2X encoder counts both phase A edges
// - 4X encoder counts all A and B edges
// - Wraparound up: past modulo returns to zero
// - Wraparound down: below zero loads modulo
// - Range limit halts at modulo or zero
// - Marker ignore mode disregards index input
// - Index clear reloads modulo on chosen edge
// - Encoder index may gate or capture count
// - Counter is 32 bits wide
// - Pulse mode: A counts, B direction, index acts
// - Values sampled on each scan start
// - Clear on read in pulse mode: capture then zero
// - Up/down: B high up, B low down
// - Gating: count while index high, else hold
// - Index capture copies count to latch
// - Pulse mode index decrement subtracts one
// - Period over 1/10/100/1000 cycles, 16/32 bit
// - Ticks of 20 ns up to 20 us
// - Pulse width between opposite A edges
// - Timing from A edge to index edge
// - Acquisition start zeroes values, first scan zero
//
// Our own choices: the register offsets and the APB slave port.
`include "mce_map.svh"

module mce_counter (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Signal source inputs
   input  wire logic        phaseA,
   input  wire logic        phaseB,
   input  wire logic        indexIn,
   // Acquisition timing
   input  wire logic        acqStart,
   input  wire logic        scanStart,
   output logic [31:0]      scanData,
   output logic             scanValid
);
   import mce_pkg::*;

   mce_state_s s;
   mce_state_s next_s;

   logic aLvl;
   logic aRise;
   logic aFall;
   logic bLvl;
   logic bRise;
   logic bFall;
   logic iLvl;
   logic iRise;
   logic iFall;

   ////////////////////////////////////////////////////////////////////////////////
   // Input edge detection

   mce_edge uEdgeA (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (phaseA),
      .level (aLvl),
      .rise  (aRise),
      .fall  (aFall)
   );

   mce_edge uEdgeB (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (phaseB),
      .level (bLvl),
      .rise  (bRise),
      .fall  (bFall)
   );

   mce_edge uEdgeI (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (indexIn),
      .level (iLvl),
      .rise  (iRise),
      .fall  (iFall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Returns {stop flag, next count} for one count step
   function automatic logic [32:0] limitStep(input logic [31:0] c,
                                             input logic [31:0] m,
                                             input logic        up,
                                             input mce_limit_e  lm);
      logic [31:0] nv;
      logic        stop;
      nv   = up ? c + 32'h1 : c - 32'h1;
      stop = 1'b0;
      case (lm)
         LIM_WRAPAROUND_LIMIT_MODE: begin
            if (up) begin
               nv = (c >= m) ? 32'h0 : c + 32'h1;
            end else begin
               nv = (c == 32'h0) ? m : c - 32'h1;
            end
         end
         LIM_RANGE: begin
            // Halted value stays; a reversed step moves off the bound
            if (up && c >= m) begin
               nv = c;
            end else if (!up && c == 32'h0) begin
               nv = c;
            end
         end
         LIM_SINGLE_SHOT: begin
            if ((up && c == 32'hffffffff) || (!up && c == 32'h0)) begin
               nv   = c;
               stop = 1'b1;
            end else if (nv == m) begin
               stop = 1'b1;
            end
         end
         default: begin
         end
      endcase
      return {stop, nv};
   endfunction

   function automatic logic [9:0] periodTarget(input logic [1:0] sel);
      logic [9:0] n;
      if (sel == 2'd0) begin
         n = `MCE_PER_N0;
      end else if (sel == 2'd1) begin
         n = `MCE_PER_N1;
      end else if (sel == 2'd2) begin
         n = `MCE_PER_N2;
      end else begin
         n = `MCE_PER_N3;
      end
      return n;
   endfunction

   // 16-bit results saturate instead of wrapping
   function automatic logic [31:0] fitResult(input logic [31:0] t, input logic wide);
      logic [31:0] r;
      r = t;
      if (!wide && t > 32'h0000ffff) begin
         r = 32'h0000ffff;
      end
      return r;
   endfunction

   function automatic logic [31:0] regRead(input logic [7:0] a, input mce_state_s st,
                                           input logic [2:0] lv);
      logic [31:0] d;
      d = 32'h0;
      if (a == `MCE_OFS_CTRL) begin
         d = {{(32-`MCE_CTRL_W){1'b0}}, st.ctrl};
      end else if (a == `MCE_OFS_MODULO) begin
         d = st.modulo;
      end else if (a == `MCE_OFS_COUNT) begin
         d = st.count;
      end else if (a == `MCE_OFS_SCAN) begin
         d = st.scanData;
      end else if (a == `MCE_OFS_IDXLATCH) begin
         d = st.idxLatch;
      end else if (a == `MCE_OFS_MEAS) begin
         d = st.measResult;
      end else if (a == `MCE_OFS_STATUS) begin
         d = {27'h0, lv, st.measRun, st.stopped};
      end
      return d;
   endfunction

   function automatic logic addrOk(input logic [7:0] a);
      return a == `MCE_OFS_CTRL || a == `MCE_OFS_MODULO || a == `MCE_OFS_COUNT ||
             a == `MCE_OFS_SCAN || a == `MCE_OFS_IDXLATCH || a == `MCE_OFS_MEAS ||
             a == `MCE_OFS_STATUS || a == `MCE_OFS_CMD;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   mce_mode_e   mode;
   mce_encres_e encRes;
   mce_limit_e  limMode;
   mce_index_e  idxMode;
   logic        cntEvt;
   logic        cntUp;
   logic        idxEdge;
   logic        swClear;
   logic        wrAccess;
   logic [32:0] step;
   logic [31:0] tickInc;
   logic [7:0]  divMax;
   logic        aStart;
   logic        aEnd;
   logic        tmStop;

   always_comb begin
      next_s    = s;
      mode      = mce_mode_e'(s.ctrl[`MCE_F_MODE_HI:`MCE_F_MODE_LO]);
      encRes    = mce_encres_e'(s.ctrl[`MCE_F_ENCRES_HI:`MCE_F_ENCRES_LO]);
      limMode   = mce_limit_e'(s.ctrl[`MCE_F_LIMIT_HI:`MCE_F_LIMIT_LO]);
      idxMode   = mce_index_e'(s.ctrl[`MCE_F_INDEX_HI:`MCE_F_INDEX_LO]);
      idxEdge   = s.ctrl[`MCE_F_IDXFALL] ? iFall : iRise;
      wrAccess  = psel && penable && pwrite;
      swClear   = wrAccess && paddr == `MCE_OFS_CMD && pwdata[`MCE_CMD_CLEAR];
      cntEvt    = 1'b0;
      cntUp     = 1'b1;
      step      = 33'h0;
      tickInc   = 32'h0;
      divMax    = 8'h0;
      aStart    = 1'b0;
      aEnd      = 1'b0;
      tmStop    = 1'b0;
      next_s.scanValid = 1'b0;

      // Software clear first, so a same-cycle stop from counting still sets
      if (swClear) begin
         next_s.count   = 32'h0;
         next_s.stopped = 1'b0;
      end

      if (mode == MODE_ENCODER) begin
         case (encRes)
            RES_1X: begin
               cntEvt = aRise;
               cntUp  = ~bLvl;
            end
            RES_2X: begin
               cntEvt = aRise | aFall;
               cntUp  = aLvl ^ bLvl;
            end
            default: begin
               cntEvt = aRise | aFall | bRise | bFall;
               cntUp  = (aRise | aFall) ? (aLvl ^ bLvl) : ~(aLvl ^ bLvl);
            end
         endcase
      end else if (mode == MODE_COUNT) begin
         cntEvt = aRise;
         cntUp  = s.ctrl[`MCE_F_UPDOWN] ? bLvl : 1'b1;
      end

      // Gate low holds the count
      if (idxMode == IDX_GATE && !iLvl) begin
         cntEvt = 1'b0;
      end

      if (cntEvt && !next_s.stopped) begin
         step         = limitStep(next_s.count, s.modulo, cntUp, limMode);
         next_s.count = step[31:0];
         if (step[32]) begin
            next_s.stopped = 1'b1;
         end
      end

      // Index clear and decrement override a count step in the same cycle
      if (idxEdge && (mode == MODE_COUNT || mode == MODE_ENCODER)) begin
         case (idxMode)
            IDX_CLEAR: begin
               next_s.count   = s.modulo;
               next_s.stopped = 1'b0;
            end
            IDX_LATCH: begin
               next_s.idxLatch = s.count;
            end
            IDX_DECREMENT: begin
               if (mode == MODE_COUNT) begin
                  next_s.count = s.count - 32'h1;
               end
            end
            default: begin
            end
         endcase
      end

      // Timebase: 20 ns ticks add several per clock, coarser ones divide
      case (s.ctrl[`MCE_F_RES_HI:`MCE_F_RES_LO])
         2'd0: divMax = 8'd1;
         2'd1: divMax = 8'(`MCE_RES1_DIV);
         2'd2: divMax = 8'(`MCE_RES2_DIV);
         default: divMax = 8'(`MCE_RES3_DIV);
      endcase
      if (s.divCnt >= divMax - 8'd1) begin
         next_s.divCnt = 8'h0;
      end else begin
         next_s.divCnt = s.divCnt + 8'd1;
      end
      if (s.ctrl[`MCE_F_RES_HI:`MCE_F_RES_LO] == 2'd0) begin
         tickInc = 32'(`MCE_RES0_INC);
      end else if (s.divCnt >= divMax - 8'd1) begin
         tickInc = 32'h1;
      end
      if (s.measRun) begin
         next_s.timer = s.timer + tickInc;
      end

      if (mode == MODE_PERIOD && aRise) begin
         if (!s.measRun) begin
            next_s.measRun = 1'b1;
            next_s.timer   = 32'h0;
            next_s.periods = 10'h0;
            next_s.divCnt  = 8'h0;
         end else if (s.periods + 10'd1 >= periodTarget(s.ctrl[`MCE_F_PERN_HI:`MCE_F_PERN_LO])) begin
            next_s.measResult = fitResult(s.timer + tickInc, s.ctrl[`MCE_F_WIDE]);
            next_s.timer      = 32'h0;
            next_s.periods    = 10'h0;
         end else begin
            next_s.periods = s.periods + 10'd1;
         end
      end else if (mode == MODE_WIDTH) begin
         aStart = s.ctrl[`MCE_F_PWFALL] ? aFall : aRise;
         aEnd   = s.ctrl[`MCE_F_PWFALL] ? aRise : aFall;
         if (aStart) begin
            next_s.measRun = 1'b1;
            next_s.timer   = 32'h0;
            next_s.divCnt  = 8'h0;
         end else if (aEnd && s.measRun) begin
            next_s.measRun    = 1'b0;
            next_s.measResult = fitResult(s.timer + tickInc, s.ctrl[`MCE_F_WIDE]);
         end
      end else if (mode == MODE_TIMING) begin
         aStart = s.ctrl[`MCE_F_TMAFALL] ? aFall : aRise;
         tmStop = s.ctrl[`MCE_F_TMIFALL] ? iFall : iRise;
         if (tmStop && s.measRun) begin
            next_s.measRun    = 1'b0;
            next_s.measResult = fitResult(s.timer + tickInc, s.ctrl[`MCE_F_WIDE]);
         end else if (aStart && !s.measRun) begin
            next_s.measRun = 1'b1;
            next_s.timer   = 32'h0;
            next_s.divCnt  = 8'h0;
         end
      end else if (mode != MODE_PERIOD) begin
         next_s.measRun = 1'b0;
      end

      // Scan capture; clear on read drops a pulse landing on the scan edge
      if (acqStart) begin
         next_s.count      = 32'h0;
         next_s.scanData   = 32'h0;
         next_s.idxLatch   = 32'h0;
         next_s.measResult = 32'h0;
         next_s.measRun    = 1'b0;
         next_s.stopped    = 1'b0;
      end else if (scanStart) begin
         next_s.scanValid = 1'b1;
         if (mode == MODE_COUNT || mode == MODE_ENCODER) begin
            next_s.scanData = s.count;
            if (mode == MODE_COUNT && s.ctrl[`MCE_F_CLRREAD]) begin
               next_s.count = 32'h0;
            end
         end else begin
            next_s.scanData = s.measResult;
         end
      end

      // APB register writes
      if (wrAccess) begin
         if (paddr == `MCE_OFS_CTRL) begin
            next_s.ctrl = pwdata[`MCE_CTRL_W-1:0];
         end else if (paddr == `MCE_OFS_MODULO) begin
            next_s.modulo = pwdata;
         end
      end

      // Read data captured in the setup phase, presented in the access phase
      if (psel && !penable && !pwrite) begin
         next_s.rdata = regRead(paddr, s, {iLvl, bLvl, aLvl});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register and outputs

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s        <= '0;
         s.ctrl   <= `MCE_CTRL_RST;
         s.modulo <= `MCE_MODULO_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata    = s.rdata;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addrOk(paddr);
   assign scanData  = s.scanData;
   assign scanValid = s.scanValid;
endmodule

// >>> dv/mce_counter_sva.sv
// Port checker of the counter unit, bound into its testbench module tb_mce_counter
`include "mce_map.svh"
module mce_counter_sva (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // APB slave
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Signal source and scan
   input wire logic        phaseA,
   input wire logic        phaseB,
   input wire logic        indexIn,
   input wire logic        acqStart,
   input wire logic        scanStart,
   input wire logic [31:0] scanData,
   input wire logic        scanValid
);
   logic [20:0] ctrlSh;
   logic [7:0]  quiet;
   logic [7:0]  gap;
   logic        lastA;
   logic        armed;
   logic        acc;
   logic        mapped;
   logic        ctrlWr;
   assign acc = psel && penable;
   assign mapped = paddr <= `MCE_OFS_CMD && paddr[1:0] == 2'b00;
   assign ctrlWr = acc && pwrite && paddr == `MCE_OFS_CTRL;
   ////////////////////////////////////////////////////////////////////////////////
   // Quiet time of phase A against scan spacing; an edge needs two cycles to land
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlSh <= '0;
         quiet  <= '0;
         gap    <= '0;
         lastA  <= 1'b0;
         armed  <= 1'b0;
      end else begin
         lastA  <= phaseA;
         quiet  <= (phaseA != lastA) ? 8'h00 : (quiet < 8'hf0) ? quiet + 8'h01 : quiet;
         gap    <= (scanStart || acqStart) ? 8'h00 : (gap < 8'hf0) ? gap + 8'h01 : gap;
         ctrlSh <= ctrlWr ? pwdata[20:0] : ctrlSh;
         armed  <= ctrlWr ? 1'b0 : (armed || scanStart || acqStart);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_scan_valid; scanStart && !acqStart |=> scanValid; endproperty
   a_scan_valid: assert property (p_scan_valid) else $error("scan not answered");
   property p_valid_cause; scanValid |-> $past(scanStart); endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("stray scan valid");
   property p_acq_zero; acqStart |=> scanData == 32'h0; endproperty
   a_acq_zero: assert property (p_acq_zero) else $error("scan data not zeroed");
   property p_scan_hold; !scanStart && !acqStart |=> $stable(scanData); endproperty
   a_scan_hold: assert property (p_scan_hold) else $error("scan data moved");
   property p_clr_read;
      ctrlSh[11] && ctrlSh[2:0] == 3'd0 && ctrlSh[9:7] == 3'd0 && armed
         && quiet > gap + 8'h02 && scanStart && !acqStart |=> scanData == 32'h0;
   endproperty
   a_clr_read: assert property (p_clr_read) else $error("count not cleared by read");
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready low in access");
   property p_err; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_no_err; !acc || mapped |-> !pslverr; endproperty
   a_no_err: assert property (p_no_err) else $error("spurious slave error");
   property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   c_scan: cover property (scanValid && scanData != 32'h0);
   c_clr: cover property (ctrlSh[11] && armed && scanStart);
   c_err: cover property (acc && pslverr);
endmodule

// >>> dv/mce_source.sv
// Pulse source and quadrature encoder model driving the count inputs
module mce_source (
   // Clock
   input wire logic clk,
   // Source outputs
   output logic     phaseA,
   output logic     phaseB,
   output logic     indexIn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      phaseA = 1'b0;
      phaseB = 1'b0;
      indexIn = 1'b0;
   end
   // Callers enter just after a rising edge; every level lasts two cycles or more
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulses(input int n, input int hi, input int lo);
      repeat (n) begin
         phaseA <= 1'b1;
         hold(hi);
         phaseA <= 1'b0;
         hold(lo);
      end
   endtask
   // A leads B: forward rotation
   task automatic quad(input int n);
      repeat (n) begin
         phaseA <= 1'b1;
         hold(3);
         phaseB <= 1'b1;
         hold(3);
         phaseA <= 1'b0;
         hold(3);
         phaseB <= 1'b0;
         hold(3);
      end
   endtask
   task automatic setB(input logic v);
      phaseB <= v;
      hold(3);
   endtask
   task automatic setI(input logic v);
      indexIn <= v;
      hold(3);
   endtask
   task automatic aThenI(input int d);
      phaseA <= 1'b1;
      hold(d);
      indexIn <= 1'b1;
      hold(3);
      phaseA <= 1'b0;
      indexIn <= 1'b0;
      hold(3);
   endtask
endmodule

// >>> dv/tb_mce_counter.sv
// Self-checking bench of the multimode counter unit
`include "mce_map.svh"
module tb_mce_counter;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic phaseA, phaseB, indexIn, acqStart, scanStart, scanValid;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, scanData, q;
   int          err_total;
   int          num_checks;
   mce_counter i_mce_counter (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn),
      .acqStart(acqStart), .scanStart(scanStart), .scanData(scanData), .scanValid(scanValid));
   mce_source i_mce_source (.clk(clk), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Idle cycle after each transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_total++;
         give_verdict();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic acq;
      acqStart <= 1'b1;
      @(posedge clk);
      acqStart <= 1'b0;
      @(posedge clk);
   endtask
   task automatic scan(input logic [31:0] x);
      int n;
      scanStart <= 1'b1;
      @(posedge clk);
      scanStart <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (scanValid !== 1'b1 && n < 8);
      if (n >= 8) begin
         err_total++;
         give_verdict();
      end
      chk(scanData, x);
   endtask
   function automatic logic [31:0] ctl(input int m, input int r, input int l, input int i);
      return 32'(m + (r << 3) + (l << 5) + (i << 7));
   endfunction
   task automatic cfg(input logic [31:0] d);
      wr(`MCE_OFS_CTRL, d);
   endtask
   task automatic cnt(input logic [31:0] x);
      rd(`MCE_OFS_COUNT, x);
   endtask
   task automatic pls(input int n, input int hi, input int lo);
      i_mce_source.pulses(n, hi, lo);
   endtask
   task automatic pinI(input logic v);
      i_mce_source.setI(v);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      acqStart = 1'b0;
      scanStart = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      num_checks = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`MCE_OFS_CTRL, 32'h0);
      rd(`MCE_OFS_MODULO, 32'hffffffff);
      rd(8'h20, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(`MCE_OFS_COUNT, 32'h55);
      cnt(32'h0);
      acq();
      scan(32'h0);
      pls(5, 2, 3);
      scan(32'h5);
      $display("test registers and scan done");
      for (int r = 0; r < 3; r++) begin
         cfg(ctl(1, r, 0, 0));
         acq();
         i_mce_source.quad(4);
         cnt(32'(4 << r));
      end
      cfg(32'h191);
      pinI(1'b1);
      pinI(1'b0);
      rd(`MCE_OFS_IDXLATCH, 32'h10);
      $display("test encoder done");
      cfg(32'h1000);
      acq();
      i_mce_source.setB(1'b1);
      pls(5, 2, 3);
      i_mce_source.setB(1'b0);
      pls(2, 2, 3);
      cnt(32'h3);
      pls(4, 2, 3);
      cnt(32'hffffffff);
      wr(`MCE_OFS_MODULO, 32'h3);
      cfg(32'h1020);
      acq();
      i_mce_source.setB(1'b1);
      pls(5, 2, 3);
      cnt(32'h1);
      i_mce_source.setB(1'b0);
      pls(3, 2, 3);
      cnt(32'h2);
      cfg(32'h1040);
      acq();
      i_mce_source.setB(1'b1);
      pls(6, 2, 3);
      cnt(32'h3);
      i_mce_source.setB(1'b0);
      pls(5, 2, 3);
      cnt(32'h0);
      i_mce_source.setB(1'b1);
      pls(1, 2, 3);
      cnt(32'h1);
      wr(`MCE_OFS_MODULO, 32'h2);
      cfg(32'h1060);
      acq();
      pls(4, 2, 3);
      cnt(32'h2);
      i_mce_source.setB(1'b0);
      pls(1, 2, 3);
      cnt(32'h2);
      wr(`MCE_OFS_CMD, 32'h1);
      i_mce_source.setB(1'b1);
      pls(1, 2, 3);
      cnt(32'h1);
      $display("test limits done");
      wr(`MCE_OFS_MODULO, 32'h7);
      cfg(32'h0);
      acq();
      pls(2, 2, 3);
      pinI(1'b1);
      pinI(1'b0);
      cnt(32'h2);
      cfg(32'h480);
      pinI(1'b1);
      cnt(32'h2);
      pinI(1'b0);
      cnt(32'h7);
      cfg(32'h100);
      pls(1, 2, 3);
      pinI(1'b1);
      pls(2, 2, 3);
      cnt(32'h9);
      cfg(32'h180);
      pinI(1'b0);
      pinI(1'b1);
      rd(`MCE_OFS_IDXLATCH, 32'h9);
      cfg(32'h200);
      pinI(1'b0);
      pinI(1'b1);
      cnt(32'h8);
      pinI(1'b0);
      cfg(32'h800);
      acq();
      pls(3, 2, 3);
      scan(32'h3);
      repeat (4) @(posedge clk);
      scan(32'h0);
      $display("test index and read clear done");
      cfg(32'h2);
      pls(4, 5, 5);
      rd(`MCE_OFS_MEAS, 32'h32);
      cfg(32'h8002);
      pls(4, 5, 5);
      rd(`MCE_OFS_MEAS, 32'h5);
      cfg(32'h22002);
      pls(21, 5, 5);
      rd(`MCE_OFS_MEAS, 32'h1f4);
      cfg(32'h6002);
      pls(2001, 7, 7);
      rd(`MCE_OFS_MEAS, 32'hffff);
      cfg(32'h3);
      pls(2, 4, 6);
      rd(`MCE_OFS_MEAS, 32'h14);
      cfg(32'h40003);
      pls(2, 4, 6);
      rd(`MCE_OFS_MEAS, 32'h1e);
      cfg(32'h10003);
      pls(2, 40, 6);
      rd(`MCE_OFS_MEAS, 32'h2);
      cfg(32'h4);
      i_mce_source.aThenI(6);
      rd(`MCE_OFS_MEAS, 32'h1e);
      $display("test measurement done");
      give_verdict();
   end
endmodule
bind tb_mce_counter mce_counter_sva i_mce_counter_sva (.clk(clk), .rst_n(rst_n), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn),
   .acqStart(acqStart), .scanStart(scanStart), .scanData(scanData), .scanValid(scanValid));
